/* File: hw/lnb_protection_diagnostics.sv */
// control register, diagnostic flags and protection sequencing
// Contract
// - lockout disables every function
// - soft-start ramps converter over 5 ms
// - 3-bit voltage code in control byte
// - compensation bit: 0 electrolytic, 1 ceramic
// - five status bits, low when fault-free
// - three flags latch until cause gone, read
// - output-low flag live while output enabled
// - pull-down flag after 10 ms deglitch
// - lockout ignores bus, zeroes control
// - bus operative once supply good
// - supply-not-good follows low-power comparator
// - overload: 90 ms on, 900 ms off, flag
// - retry on-time, repeat while overload persists
// - clean on-time returns normal; flag read-clears
// - overtemperature shuts stages, sets flag
// - overtemperature recovery automatic; flag read-clears
`timescale 1ns/1ns
module lnb_protection_diagnostics
  import lnb_pkg::*;
#(
  parameter int unsigned  TON_CYCLES    = TON_CYC,      // overload on-time
  parameter int unsigned  TOFF_CYCLES   = TOFF_CYC,     // overload off-time
  parameter int unsigned  PDO_CYCLES    = PDO_CYC,      // sink deglitch time
  parameter int unsigned  SS_STEP_CYCLES = SS_STEP_CYC, // cycles per ramp level
  parameter logic [6:0]   DEV_ADDR_BASE = 7'h0A         // arbitrary value
) (
  input  wire logic    ref_clk,   // internal oscillator
  input  wire logic    rst,       // asynchronous reset, active high
  input  wire logic    scl_clk,   // serial bus clock
  input  wire logic    sda_in,    // serial data level
  output wire logic    sda_out,   // serial data drive value
  output wire logic    sda_oe,    // serial data drive enable
  input  wire logic    addr_sel,  // bus address strap
  input  wire analog_t ana,       // comparator indications
  output wire pwr_t    pwr        // power stage controls
);

  localparam int TMR_W = $clog2(TOFF_CYCLES + 1);     // shared timer width
  localparam int PDO_W = $clog2(PDO_CYCLES + 1);      // deglitch counter width
  localparam int SS_W  = $clog2(SS_STEP_CYCLES + 1);  // ramp prescaler width
  localparam logic [TMR_W-1:0] TON_LAST  = TMR_W'(TON_CYCLES - 1);
  localparam logic [TMR_W-1:0] TOFF_LAST = TMR_W'(TOFF_CYCLES - 1);
  localparam logic [PDO_W-1:0] PDO_LAST  = PDO_W'(PDO_CYCLES - 1);
  localparam logic [SS_W-1:0]  SS_LAST   = SS_W'(SS_STEP_CYCLES - 1);

  typedef struct packed {
    analog_t          a_s1;    // comparator sync stage 1
    analog_t          a_s2;    // comparator sync stage 2
    logic             wr_s1;   // write toggle sync 1
    logic             wr_s2;   // write toggle sync 2
    logic             wr_s3;   // write toggle last value
    logic             rd_s1;   // read toggle sync 1
    logic             rd_s2;   // read toggle sync 2
    logic             rd_s3;   // read toggle last value
    ctl_t             ctl;     // output_control
    status_t          sts;     // diagnostic_status
    prot_state_t      prot;    // overload sequencer
    logic             seen;    // overload seen in this on-time
    logic [TMR_W-1:0] tmr;     // on/off timer
    logic [PDO_W-1:0] pdo_cnt; // sink overcurrent duration
    logic [SS_W-1:0]  ss_pre;  // ramp prescaler
    pwr_t             pwr;     // stage controls
  } core_state_t;

  core_state_t q;        // registered state
  core_state_t n;        // next state
  logic        link_wr;  // write toggle from link
  logic [7:0]  link_dat; // write value from link
  logic        link_rd;  // read toggle from link
  logic        uv;       // lockout, synchronised
  logic        wr_evt;   // control write arrived
  logic        rd_evt;   // status read happened
  logic        ol_set;   // overload off-time begins
  logic        on;       // stages may run

  // serial slave on the bus clock
  lnb_i2c_link #(
    .DEV_ADDR_BASE (DEV_ADDR_BASE)
  ) u_link (
    .scl_clk   (scl_clk),
    .rst       (rst),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .addr_sel  (addr_sel),
    .uvlo      (q.a_s2.uvlo),
    .status_in (q.sts),
    .ctl_in    (q.ctl),
    .wr_tgl    (link_wr),
    .wr_data   (link_dat),
    .rd_tgl    (link_rd)
  );

  // next state on each reference clock edge
  always_comb begin
    n      = q;
    ol_set = 1'h0;
    n.a_s1  = ana;
    n.a_s2  = q.a_s1;
    // event toggles from the bus domain
    n.wr_s1 = link_wr;
    n.wr_s2 = q.wr_s1;
    n.wr_s3 = q.wr_s2;
    n.rd_s1 = link_rd;
    n.rd_s2 = q.rd_s1;
    n.rd_s3 = q.rd_s2;
    uv      = q.a_s2.uvlo;
    wr_evt  = q.wr_s2 ^ q.wr_s3;
    rd_evt  = q.rd_s2 ^ q.rd_s3;

    // control byte held stable by the link
    // store whole control byte
    if (wr_evt) begin
      n.ctl = ctl_t'(link_dat);
    end

    case (q.prot)
      // watch for overload
      PR_NORMAL: begin
        if (q.a_s2.overload) begin
          n.prot = PR_ON;
          n.seen = 1'h1;
          n.tmr  = '0;
        end
      end
      PR_ON: begin
        n.tmr  = q.tmr + TMR_W'(1);
        n.seen = q.seen | q.a_s2.overload;
        if (q.tmr == TON_LAST) begin
          n.tmr = '0;
          if (n.seen) begin
            n.prot = PR_OFF;
            ol_set = 1'h1;
          end else begin
            n.prot = PR_NORMAL;
          end
        end
      end
      PR_OFF: begin
        n.tmr = q.tmr + TMR_W'(1);
        if (q.tmr == TOFF_LAST) begin
          n.tmr  = '0;
          n.seen = 1'h0;
          n.prot = PR_ON;
        end
      end
      default: begin
        n.prot = PR_NORMAL;
      end
    endcase

    if (!q.a_s2.sink_oc) begin
      n.pdo_cnt = '0;
    end else if (q.pdo_cnt != PDO_LAST) begin
      n.pdo_cnt = q.pdo_cnt + PDO_W'(1);
    end

    n.sts.rsvd = 3'h0;
    // latched flags, set wins over read
    // overload clears on read once normal
    n.sts.overload_flag = ol_set
                        | (q.sts.overload_flag & ~(rd_evt & (q.prot == PR_NORMAL)));
    n.sts.overtemperature_flag = q.a_s2.overtemp
                               | (q.sts.overtemperature_flag & ~rd_evt);
    n.sts.supply_not_good_flag = q.a_s2.low_power_diagnostic
                               | (q.sts.supply_not_good_flag & ~rd_evt);
    n.sts.output_low_flag = q.pwr.linreg_en & q.a_s2.out_low;
    n.sts.pulldown_overcurrent_flag = q.a_s2.sink_oc & (q.pdo_cnt == PDO_LAST);

    // thermal event or off-time stops stages
    on               = q.ctl.enable & ~uv & ~q.a_s2.overtemp & (q.prot != PR_OFF);
    n.pwr.boost_en   = on;
    n.pwr.linreg_en  = on;
    n.pwr.comp_ceramic = q.ctl.comp;
    n.pwr.vsel       = q.ctl.vsel;

    if (!q.pwr.boost_en) begin
      n.ss_pre       = '0;
      n.pwr.ss_level = 8'h00;
    end else if (q.pwr.ss_level != 8'hFF) begin
      n.ss_pre = q.ss_pre + SS_W'(1);
      if (q.ss_pre == SS_LAST) begin
        n.ss_pre       = '0;
        n.pwr.ss_level = q.pwr.ss_level + 8'h01;
      end
    end

    if (uv) begin
      n.ctl     = ctl_t'(CTL_RESET);
      n.sts     = status_t'(STS_RESET);
      n.prot    = PR_NORMAL;
      n.seen    = 1'h0;
      n.tmr     = '0;
      n.pdo_cnt = '0;
      n.ss_pre  = '0;
      n.pwr     = '0;
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // stage controls straight from flops
  assign pwr = q.pwr;

endmodule

/* File: hw/lnb_pkg.sv */
// shared constants, types and carriers of the supply regulator control logic
package lnb_pkg;

  // register indices on the serial bus
  localparam logic       REG_STATUS_IDX  = 1'h0;  // diagnostic_status
  localparam logic       REG_CONTROL_IDX = 1'h1;  // output_control
  localparam logic [7:0] CTL_RESET       = 8'h00; // output_control after reset
  localparam logic [7:0] STS_RESET       = 8'h00; // diagnostic_status after reset

  // reference clock rate in kHz, so that ms times times this give cycles
  localparam int unsigned REF_CLK_KHZ = 100000;

  // protection and start-up times, in ms as printed
  localparam int unsigned TON_MS      = 90;   // overload on-time
  localparam int unsigned TOFF_MS     = 900;  // overload off-time
  localparam int unsigned PDO_MS      = 10;   // sink overcurrent deglitch
  localparam int unsigned SS_MS       = 5;    // soft-start ramp length
  localparam int unsigned SS_STEPS    = 256;  // ramp levels

  // derived cycle counts
  localparam int unsigned TON_CYC     = TON_MS * REF_CLK_KHZ;
  localparam int unsigned TOFF_CYC    = TOFF_MS * REF_CLK_KHZ;
  localparam int unsigned PDO_CYC     = PDO_MS * REF_CLK_KHZ;
  localparam int unsigned SS_CYC      = SS_MS * REF_CLK_KHZ;
  localparam int unsigned SS_STEP_CYC = SS_CYC / SS_STEPS;

  // serial byte length less one
  localparam logic [2:0] LAST_BIT = 3'h7;

  // output_control layout
  typedef struct packed {
    logic [2:0] rsvd;    // reads back as written, no effect
    logic       enable;  // output on
    logic       comp;    // 0 electrolytic, 1 ceramic loop
    logic [2:0] vsel;    // output voltage code
  } ctl_t;

  // diagnostic_status layout
  typedef struct packed {
    logic [2:0] rsvd;                       // read as zero
    logic       pulldown_overcurrent_flag;  // deglitched sink overcurrent
    logic       output_low_flag;            // output below limit, live
    logic       supply_not_good_flag;       // latched low supply
    logic       overtemperature_flag;       // latched thermal event
    logic       overload_flag;              // latched overload
  } status_t;

  // analog comparator indications, asynchronous to every clock
  typedef struct packed {
    logic uvlo;                 // supply below lockout
    logic low_power_diagnostic; // supply below minimum
    logic overload;             // output current limit reached
    logic overtemp;             // junction too hot
    logic sink_oc;              // pull-down stage overcurrent
    logic out_low;              // regulated_output below limit
  } analog_t;

  // controls towards the power stages
  typedef struct packed {
    logic       boost_en;      // step-up converter on
    logic       linreg_en;     // linear regulator on
    logic       comp_ceramic;  // loop compensation choice
    logic [2:0] vsel;          // voltage code
    logic [7:0] ss_level;      // soft-start reference level
  } pwr_t;

  // protection sequencer states
  typedef enum logic [1:0] {
    PR_NORMAL = 2'h0,
    PR_ON     = 2'h1,
    PR_OFF    = 2'h2
  } prot_state_t;

  // serial link phases
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_ADDR  = 3'h1,
    PH_SUB   = 3'h2,
    PH_WDATA = 3'h3,
    PH_ACK   = 3'h4,
    PH_TX    = 3'h5,
    PH_MACK  = 3'h6
  } link_phase_t;

endpackage

/* File: hw/lnb_i2c_link.sv */
// serial bus slave running on the bus clock
`timescale 1ns/1ns
module lnb_i2c_link
  import lnb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR_BASE = 7'h0A  // arbitrary value, lsb from addr_sel
) (
  input  wire logic       scl_clk,    // bus clock
  input  wire logic       rst,        // asynchronous reset
  input  wire logic       sda_in,     // bus data level
  output wire logic       sda_out,    // bus data drive value
  output wire logic       sda_oe,     // bus data drive enable
  input  wire logic       addr_sel,   // address strap pin
  input  wire logic       uvlo,       // lockout level from core
  input  wire logic [7:0] status_in,  // status byte from core
  input  wire logic [7:0] ctl_in,     // control byte from core
  output wire logic       wr_tgl,     // toggles per control write
  output wire logic [7:0] wr_data,    // held control write value
  output wire logic       rd_tgl      // toggles per status read
);

  typedef struct packed {
    logic        sel_s1;      // strap sync stage 1
    logic        sel_s2;      // strap sync stage 2
    logic        uv_s1;       // lockout sync stage 1
    logic        uv_s2;       // lockout sync stage 2
    logic [7:0]  sts_s1;      // status sync stage 1
    logic [7:0]  sts_s2;      // status sync stage 2
    logic [7:0]  ctl_s1;      // control sync stage 1
    logic [7:0]  ctl_s2;      // control sync stage 2
    logic        start_seen;  // last start toggle handled
    link_phase_t phase;       // current phase
    link_phase_t after;       // phase after acknowledge
    logic [2:0]  bitcnt;      // bit within byte
    logic [7:0]  shreg;       // receive shifter
    logic [7:0]  txreg;       // transmit shifter
    logic        ptr;         // register index
    logic        ack;         // acknowledge pending
    logic        wr_tgl;      // write event toggle
    logic [7:0]  wr_data;     // write value
    logic        rd_tgl;      // read event toggle
  } link_state_t;

  link_state_t q;           // registered state
  link_state_t n;           // next state
  logic        start_tgl_q; // flips on each start condition
  logic        sda_oe_q;    // drive enable, changes on falling edge
  logic [7:0]  rx_byte;     // byte completed this edge
  logic        load;        // load next transmit byte
  logic        drive_low;   // pull data low after falling edge

  // start condition: data falls while clock is high
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'h0;
    end else if (scl_clk) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // next state on each rising bus clock edge
  always_comb begin
    n         = q;
    load      = 1'h0;
    rx_byte   = {q.shreg[6:0], sda_in};
    // strap and core levels, two flops each
    n.sel_s1  = addr_sel;
    n.sel_s2  = q.sel_s1;
    n.uv_s1   = uvlo;
    n.uv_s2   = q.uv_s1;
    n.sts_s1  = status_in;
    n.sts_s2  = q.sts_s1;
    n.ctl_s1  = ctl_in;
    n.ctl_s2  = q.ctl_s1;
    // start settles a full half period before this edge
    if (start_tgl_q != q.start_seen) begin
      n.start_seen = start_tgl_q;
      n.phase      = PH_ADDR;
      n.shreg      = {7'h00, sda_in};
      n.bitcnt     = 3'h1;
      n.ack        = 1'h0;
    end else begin
      case (q.phase)
        // receiving bytes
        PH_ADDR, PH_SUB, PH_WDATA: begin
          n.shreg  = rx_byte;
          n.bitcnt = q.bitcnt + 3'h1;
          if (q.bitcnt == LAST_BIT) begin
            n.phase = PH_ACK;
            n.ack   = 1'h1;
            if (q.phase == PH_ADDR) begin
              if (rx_byte[7:1] == {DEV_ADDR_BASE[6:1], q.sel_s2} && !q.uv_s2) begin
                n.after = rx_byte[0] ? PH_TX : PH_SUB;
                n.ptr   = REG_STATUS_IDX;
              end else begin
                n.phase = PH_IDLE;
                n.ack   = 1'h0;
              end
            end else if (q.phase == PH_SUB) begin
              n.ptr   = rx_byte[0];
              n.after = PH_WDATA;
            end else begin
              if (q.ptr == REG_CONTROL_IDX) begin
                n.wr_data = rx_byte;
                n.wr_tgl  = ~q.wr_tgl;
              end
              n.ptr   = ~q.ptr;
              n.after = PH_WDATA;
            end
          end
        end
        // ninth clock, our acknowledge
        PH_ACK: begin
          n.ack    = 1'h0;
          n.bitcnt = 3'h0;
          n.phase  = q.after;
          load     = (q.after == PH_TX);
        end
        // sending a byte
        PH_TX: begin
          n.txreg  = {q.txreg[6:0], 1'h0};
          n.bitcnt = q.bitcnt + 3'h1;
          if (q.bitcnt == LAST_BIT) begin
            n.phase = PH_MACK;
          end
        end
        // master acknowledge: low continues
        PH_MACK: begin
          if (!sda_in) begin
            n.phase = PH_TX;
            load    = 1'h1;
          end else begin
            n.phase = PH_IDLE;
          end
        end
        default: begin
          n.phase = PH_IDLE;
        end
      endcase
    end
    // snapshot next byte; status snapshot marks a read
    if (load) begin
      n.txreg  = (q.ptr == REG_CONTROL_IDX) ? q.ctl_s2 : q.sts_s2;
      n.rd_tgl = q.rd_tgl ^ (q.ptr == REG_STATUS_IDX);
      n.ptr    = ~q.ptr;
    end
  end

  // state register
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // data line driven from the falling edge
  assign drive_low = q.ack | ((q.phase == PH_TX) & ~q.txreg[7]);

  // drive enable register
  always_ff @(negedge scl_clk or posedge rst) begin
    if (rst) begin
      sda_oe_q <= 1'h0;
    end else begin
      sda_oe_q <= drive_low;
    end
  end

  assign sda_out = 1'h0;
  assign sda_oe  = sda_oe_q;
  assign wr_tgl  = q.wr_tgl;
  assign wr_data = q.wr_data;
  assign rd_tgl  = q.rd_tgl;

endmodule

/* File: dv/lnb_host_model.sv */
// bus master model of the host microcontroller
`timescale 1ns/1ns
module lnb_host_model (
  output logic      scl_clk,  // bus clock, high between frames
  output logic      sda_drv,  // 0 pulls data low, 1 releases
  input  wire logic sda_wire  // resolved data line
);
  localparam int QTR = 16;  // quarter of the 64 ns bus period

  // bus idle at power-up
  initial begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end

  // one bit: data set while clock low, sampled at the rise
  task automatic bit_io(input logic b, output logic r);
    scl_clk = 1'b0;
    #QTR sda_drv = b;
    #QTR scl_clk = 1'b1;
    r = sda_wire;
    #(2*QTR);
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic a_in,
                         output logic [7:0] rx, output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(a_in, a_out);
  endtask

  // data falls while clock high
  task automatic start_cond();
    sda_drv = 1'b1;
    scl_clk = 1'b1;
    #(2*QTR) sda_drv = 1'b0;
    #(2*QTR);
  endtask

  // data rises while clock high, clock then stands
  task automatic stop_cond();
    scl_clk = 1'b0;
    #QTR sda_drv = 1'b0;
    #QTR scl_clk = 1'b1;
    #(2*QTR) sda_drv = 1'b1;
    #(2*QTR);
  endtask

  task automatic write_frame(input logic [6:0] addr, input logic [7:0] data,
                             output logic acked);
    logic [7:0] rx;
    logic       a;
    start_cond();
    byte_io({addr, 1'b0}, 1'b1, rx, a);
    acked = ~a;
    byte_io(8'h01, 1'b1, rx, a);
    byte_io(data, 1'b1, rx, a);
    stop_cond();
  endtask

  // status then control, nack ends
  task automatic read_frame(input logic [6:0] addr, output logic [7:0] sts,
                            output logic [7:0] ctl);
    logic [7:0] rx;
    logic       a;
    start_cond();
    byte_io({addr, 1'b1}, 1'b1, rx, a);
    byte_io(8'hFF, 1'b0, sts, a);
    byte_io(8'hFF, 1'b1, ctl, a);
    stop_cond();
  endtask
endmodule

/* File: dv/lnb_protection_diagnostics_checker.sv */
// port assertions of the regulator control logic
`timescale 1ns/1ns
module lnb_protection_diagnostics_checker
  import lnb_pkg::*;
#(
  parameter int unsigned TON_CYCLES     = TON_CYC,    // overload on-time
  parameter int unsigned TOFF_CYCLES    = TOFF_CYC,   // overload off-time
  parameter int unsigned PDO_CYCLES     = PDO_CYC,    // sink deglitch time
  parameter int unsigned SS_STEP_CYCLES = SS_STEP_CYC // cycles per ramp level
) (
  input wire logic    ref_clk,  // core clock
  input wire logic    rst,      // asynchronous reset
  input wire logic    scl_clk,  // bus clock
  input wire logic    sda_in,   // bus data level
  input wire logic    sda_out,  // bus drive value
  input wire logic    sda_oe,   // bus drive enable
  input wire logic    addr_sel, // address strap
  input wire analog_t ana,      // comparator levels
  input wire pwr_t    pwr       // power stage controls
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // lockout held past the synchroniser
  sequence s_uvlo_held;
    ana.uvlo [*5];
  endsequence
  // hot junction held past the synchroniser
  sequence s_hot_held;
    ana.overtemp [*5];
  endsequence
  // both stages held off
  sequence s_off_hold;
    (!pwr.linreg_en && !pwr.boost_en) [*8];
  endsequence

  property p_uvlo_off;
    s_uvlo_held |-> pwr == 14'h0000;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("outputs live in lockout");
  property p_oe_uvlo;
    s_uvlo_held |-> !sda_oe;
  endproperty
  a_oe_uvlo: assert property (p_oe_uvlo) else $error("bus driven in lockout");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_clk;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved at clock high");
  property p_ot_off;
    s_hot_held |-> !pwr.boost_en && !pwr.linreg_en;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("stages on while hot");
  property p_ss_zero;
    (!pwr.boost_en) [*2] |-> pwr.ss_level == 8'h00;
  endproperty
  a_ss_zero: assert property (p_ss_zero) else $error("ramp level with converter off");
  property p_ss_step;
    pwr.boost_en && $past(pwr.boost_en) && $changed(pwr.ss_level)
      |-> pwr.ss_level == $past(pwr.ss_level) + 8'h01;
  endproperty
  a_ss_step: assert property (p_ss_step) else $error("ramp step not one");
  property p_ss_sat;
    pwr.boost_en && pwr.ss_level == 8'hFF |=> pwr.ss_level == 8'hFF || !pwr.boost_en;
  endproperty
  a_ss_sat: assert property (p_ss_sat) else $error("ramp passed full scale");
  property p_ol_off;
    $fell(pwr.linreg_en) && ana.overload && !ana.overtemp && !ana.uvlo |-> s_off_hold;
  endproperty
  a_ol_off: assert property (p_ol_off) else $error("off-time cut short");
endmodule

bind lnb_protection_diagnostics lnb_protection_diagnostics_checker #(
  .TON_CYCLES(TON_CYCLES), .TOFF_CYCLES(TOFF_CYCLES),
  .PDO_CYCLES(PDO_CYCLES), .SS_STEP_CYCLES(SS_STEP_CYCLES)
) u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .ana(ana), .pwr(pwr)
);

/* File: dv/tb_top.sv */
// self-checking bench of the regulator control logic
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  import lnb_pkg::*;
  localparam int unsigned TON  = 20;     // shortened on-time
  localparam int unsigned TOFF = 50;     // shortened off-time
  localparam int unsigned PULLDOWN_OVERCURRENT_FLAG  = 10;     // shortened deglitch
  localparam logic [6:0]  DEV  = 7'h0B;  // base address with strap high
  logic       ref_clk = 1'b0;    // core clock
  logic       rst = 1'b1;        // reset
  logic       scl_clk;           // bus clock from host
  logic       sda_drv;           // host data drive
  wire logic  sda_in;            // resolved data line
  wire logic  sda_out;           // device drive value
  wire logic  sda_oe;            // device drive enable
  logic       addr_sel = 1'b1;   // strap high
  analog_t    ana = 6'h20;       // lockout at power-up
  pwr_t       pwr;               // power stage controls
  logic [7:0] sts;               // status read back
  logic [7:0] ctl;               // control read back
  logic       ack;               // address acknowledged
  int         n;                 // cycle count
  int         cyc = 0;           // timeout counter
  int         n_mismatch = 0;    // failed compares
  int         total_checks = 0;  // compares made

  // 100 MHz core clock
  always #5 ref_clk = ~ref_clk;
  // open-drain data line with pull-up
  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

  lnb_protection_diagnostics #(
    .TON_CYCLES(TON), .TOFF_CYCLES(TOFF), .PDO_CYCLES(PULLDOWN_OVERCURRENT_FLAG), .SS_STEP_CYCLES(2)
  ) u_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .ana(ana), .pwr(pwr)
  );
  lnb_host_model u_host (.scl_clk(scl_clk), .sda_drv(sda_drv), .sda_wire(sda_in));

  // wait whole core cycles
  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // read both registers, compare status
  task automatic rd_chk(input logic [7:0] exp);
    u_host.read_frame(DEV, sts, ctl);
    `CHK(sts, exp)
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    cycles(2);
    u_host.stop_cond();
    cycles(20);
    rst <= 1'b0;
    cycles(4);
    // lockout: command refused, outputs off
    u_host.write_frame(DEV, 8'h1D, ack);
    `CHK(ack, 1'b0)
    `CHK(pwr, 14'h0000)
    @(posedge ref_clk) ana.uvlo <= 1'b0;
    cycles(4);
    // other strap address refused
    u_host.write_frame(DEV ^ 7'h01, 8'h1D, ack);
    `CHK(ack, 1'b0)
    // supply good: voltage code, ceramic loop, enable
    u_host.write_frame(DEV, 8'h1D, ack);
    cycles(6);
    `CHK(ack, 1'b1)
    `CHK(sda_out, 1'b0)
    `CHK({pwr.boost_en, pwr.linreg_en, pwr.comp_ceramic, pwr.vsel}, 6'h3D)
    `CHK(pwr.ss_level < 8'h10, 1'b1)
    cycles(600);
    `CHK(pwr.ss_level, 8'hFF)
    rd_chk(8'h00);
    `CHK(ctl, 8'h1D)
    u_host.write_frame(DEV, 8'h12, ack);
    cycles(6);
    `CHK({pwr.boost_en, pwr.linreg_en, pwr.comp_ceramic, pwr.vsel}, 6'h32)
    // live output-low flag
    @(posedge ref_clk) ana.out_low <= 1'b1;
    rd_chk(8'h08);
    @(posedge ref_clk) ana.out_low <= 1'b0;
    rd_chk(8'h00);
    // short sink overcurrent filtered, long one flagged
    @(posedge ref_clk) ana.sink_oc <= 1'b1;
    cycles(PULLDOWN_OVERCURRENT_FLAG - 4);
    ana.sink_oc <= 1'b0;
    rd_chk(8'h00);
    @(posedge ref_clk) ana.sink_oc <= 1'b1;
    cycles(PULLDOWN_OVERCURRENT_FLAG + 5);
    rd_chk(8'h10);
    @(posedge ref_clk) ana.sink_oc <= 1'b0;
    // low supply flag latches until read
    @(posedge ref_clk) ana.low_power_diagnostic <= 1'b1;
    cycles(4);
    rd_chk(8'h04);
    @(posedge ref_clk) ana.low_power_diagnostic <= 1'b0;
    rd_chk(8'h04);
    rd_chk(8'h00);
    // overload: on-time, off-time, retry, recovery
    @(posedge ref_clk) ana.overload <= 1'b1;
    n = 0;
    while (pwr.linreg_en === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK(n >= TON && n <= TON + 5, 1'b1)
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (pwr.linreg_en !== 1'b1 && n < 200) begin
        @(posedge ref_clk) if (k == 1 && n == TOFF - 10) ana.overload <= 1'b0;
        #1 n++;
      end
      `CHK(n >= TOFF - 1 && n <= TOFF + 2, 1'b1)
      n = 0;
      while (pwr.linreg_en === 1'b1 && n < TON + 10) begin
        @(posedge ref_clk);
        #1 n++;
      end
      `CHK(k == 0 ? (n >= TON - 1 && n <= TON + 2) : (n == TON + 10), 1'b1)
    end
    rd_chk(8'h01);
    rd_chk(8'h00);
    // thermal shutdown and automatic resume
    @(posedge ref_clk) ana.overtemp <= 1'b1;
    cycles(6);
    `CHK({pwr.boost_en, pwr.linreg_en}, 2'b00)
    rd_chk(8'h02);
    @(posedge ref_clk) ana.overtemp <= 1'b0;
    cycles(6);
    `CHK({pwr.boost_en, pwr.linreg_en}, 2'b11)
    rd_chk(8'h02);
    rd_chk(8'h00);
    // lockout in mid-run clears control
    @(posedge ref_clk) ana.uvlo <= 1'b1;
    cycles(6);
    `CHK(pwr, 14'h0000)
    @(posedge ref_clk) ana.uvlo <= 1'b0;
    cycles(4);
    u_host.write_frame(DEV ^ 7'h01, 8'h1D, ack);
    rd_chk(8'h00);
    `CHK(ctl, 8'h00)
    finish_test();
  end
endmodule
